/* inc/srf_addr_pkg.sv */
// constants and types shared by the screen-refresh address generator
`default_nettype none
package srf_addr_pkg;
   // register byte offsets on the apb bus
   localparam logic [7:0] OFF_ADR = 8'h00;
   localparam logic [7:0] OFF_CTL = 8'h04;
   localparam logic [7:0] OFF_STRT = 8'h08;
   localparam logic [7:0] OFF_TAP = 8'h0C;
   localparam logic [7:0] OFF_STAT = 8'h10;
   // field positions
   localparam int CNT_LSB = 2;
   localparam int CNT_MSB = 15;
   localparam int PITCH_LSB = 2;
   localparam int PITCH_MSB = 9;
   localparam int ORIGIN_BIT = 10;
   localparam int NONINTERLACE_BIT = 15;
   // reset values
   localparam logic [15:0] ADR_RST = 16'h0000;
   localparam logic [15:0] CTL_RST = 16'h0000;
   localparam logic [15:0] STRT_RST = 16'h0000;
   localparam logic [15:0] TAP_RST = 16'h0000;
   // fixed status levels on the local lines
   localparam logic [2:0] ROW_HIGH_ZERO = 3'h0;
   localparam logic ROW_REFRESH_FLAG = 1'b1;
   localparam logic [1:0] COL_STATUS = 2'h0;

   typedef enum {
      ST_IDLE,
      ST_ROW,
      ST_COL,
      ST_UPDATE
   } srf_state_t;

   // events from the video timing counters, same clock
   typedef struct packed {
      logic hblank_start;
      logic vblank;
      logic last_line;
      logic first_line_next;
      logic even_field;
   } vid_timing_t;

   // address driven onto the local address/data lines
   typedef struct packed {
      logic [15:0] data;
      logic oe_n;
      logic row_phase;
      logic col_phase;
   } lad_drive_t;
endpackage : srf_addr_pkg
`default_nettype wire

/* design/srf_addr_gen.sv */
// screen-refresh address generator with apb register access
// Functional notes
// - request refresh at each horizontal blanking start
// - cycle is a memory-to-shift-register transfer
// - twelve-bit row address selects transferred row
// - reload counter bits 2-15 from frame start
// - reload at blanking after last active line
// - counter is fourteen bits, bits 2-15
// - row time drives counter bits 4-15
// - origin zero inverts counter bits on output
// - row time lines 12-14 low, 15 high
// - column lines 6-10 are counter OR pan
// - column lines 0-5, 11-13 come from pan
// - column time lines 14 and 15 low
// - subtract pitch field from counter after cycle
// - origin zero gives effective increment
// - interlace bit selects interlaced or noninterlaced
// - pan and counter overlap bits are ORed
// - refresh beats all cycles except hold
// - no refresh in vertical blanking except last
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module srf_addr_gen (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // video timing and memory controller
   input wire srf_addr_pkg::vid_timing_t vid,
   input wire logic hold_req,
   // local address/data lines
   output srf_addr_pkg::lad_drive_t local_addr_data_lines,
   output logic srf_busy
);
   import srf_addr_pkg::*;

   function automatic logic [13:0] origin_view(input logic [13:0] v,
                                               input logic keep);
      origin_view = keep ? v : ~v;
   endfunction : origin_view

   ////////////////////////////////////////////////////////////////////
   // registers and state
   logic [15:0] adr_q, adr_d;
   logic [15:0] ctl_q;
   logic [15:0] strt_q;
   logic [15:0] tap_q;
   logic pend_q;
   logic field_q;
   srf_state_t st_q, st_d;
   lad_drive_t lad_q, lad_d;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic busy_q;

   ////////////////////////////////////////////////////////////////////
   // decode
   wire logic access = psel & penable;
   wire logic commit = access & pready_q;
   wire logic hit_adr = paddr == OFF_ADR;
   wire logic hit_ctl = paddr == OFF_CTL;
   wire logic hit_strt = paddr == OFF_STRT;
   wire logic hit_tap = paddr == OFF_TAP;
   wire logic hit_stat = paddr == OFF_STAT;
   wire logic mapped = hit_adr | hit_ctl | hit_strt | hit_tap | hit_stat;
   wire logic wr_ok = commit & pwrite & mapped;

   wire logic origin = ctl_q[ORIGIN_BIT];
   wire logic progressive = ctl_q[NONINTERLACE_BIT];
   wire logic [7:0] pitch = ctl_q[PITCH_MSB:PITCH_LSB];
   wire logic [13:0] cnt = adr_q[CNT_MSB:CNT_LSB];
   wire logic [13:0] cnt_out = origin_view(cnt, origin);

   ////////////////////////////////////////////////////////////////////
   // refresh requests and frame reload
   // only the line right before the first active line refreshes in vblank
   wire logic req_ev = vid.hblank_start &
                       (~vid.vblank | vid.first_line_next);
   wire logic reload = vid.hblank_start & vid.last_line;
   // half a pitch offsets the even field of an interlaced frame
   wire logic [13:0] half_step = {7'h00, pitch[7:1]};
   wire logic [13:0] start_cnt = strt_q[CNT_MSB:CNT_LSB];
   wire logic [13:0] reload_cnt = (~progressive & vid.even_field) ?
                                  start_cnt - half_step :
                                  start_cnt;
   wire logic [13:0] step_cnt = cnt - {6'h00, pitch};

   // nothing but an external hold or a refresh cycle still running may postpone the refresh
   wire logic take = pend_q & (st_q == ST_IDLE) & ~hold_req;

   ////////////////////////////////////////////////////////////////////
   // local line contents
   wire logic [15:0] row_word = {ROW_REFRESH_FLAG, ROW_HIGH_ZERO,
                                 cnt_out[13:2]};
   wire logic [15:0] col_word = {COL_STATUS, tap_q[13:11],
                                 cnt_out[4:0] | tap_q[10:6],
                                 tap_q[5:0]};

   always_comb begin
      st_d = st_q;
      lad_d = '{data: 16'h0000, oe_n: 1'b1, row_phase: 1'b0,
                col_phase: 1'b0};
      case (st_q)
         ST_IDLE: begin
            if (take) begin
               st_d = ST_ROW;
               lad_d = '{data: row_word, oe_n: 1'b0, row_phase: 1'b1,
                         col_phase: 1'b0};
            end
         end
         ST_ROW: begin
            st_d = ST_COL;
            lad_d = '{data: col_word, oe_n: 1'b0, row_phase: 1'b0,
                      col_phase: 1'b1};
         end
         ST_COL: begin
            st_d = ST_UPDATE;
         end
         ST_UPDATE: begin
            st_d = ST_IDLE;
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   // counter: frame reload beats step, step beats software write
   always_comb begin
      adr_d = adr_q;
      if (wr_ok & hit_adr) begin
         adr_d = {pwdata[15:2], 2'b00};
      end
      if (st_q == ST_UPDATE) begin
         adr_d = {step_cnt, 2'b00};
      end
      if (reload) begin
         adr_d = {reload_cnt, 2'b00};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // read mux
   wire logic [15:0] stat_word = {13'h0000, field_q, pend_q,
                                  st_q != ST_IDLE};
   wire logic [15:0] rd_word = hit_adr ? adr_q :
                               hit_ctl ? ctl_q :
                               hit_strt ? strt_q :
                               hit_tap ? tap_q :
                               hit_stat ? stat_word : 16'h0000;

   ////////////////////////////////////////////////////////////////////
   // flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE;
         lad_q <= '{data: 16'h0000, oe_n: 1'b1, row_phase: 1'b0,
                    col_phase: 1'b0};
         pend_q <= 1'b0;
         field_q <= 1'b0;
         adr_q <= ADR_RST;
         busy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         busy_q <= st_d != ST_IDLE;
         lad_q <= lad_d;
         // a new request wins over the take in the same cycle
         pend_q <= req_ev | (pend_q & ~take);
         field_q <= reload ? vid.even_field : field_q;
         adr_q <= adr_d;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_q <= CTL_RST;
         strt_q <= STRT_RST;
         tap_q <= TAP_RST;
      end else begin
         ctl_q <= (wr_ok & hit_ctl) ? pwdata[15:0] : ctl_q;
         strt_q <= (wr_ok & hit_strt) ? {pwdata[15:2], 2'b00} : strt_q;
         tap_q <= (wr_ok & hit_tap) ? pwdata[15:0] : tap_q;
      end
   end

   // one wait state: ready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= access & ~pready_q;
         pslverr_q <= access & ~pready_q & ~mapped;
         prdata_q <= (access & ~pready_q & ~pwrite) ?
                     {16'h0000, rd_word} : 32'h0000_0000;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign local_addr_data_lines = lad_q;
   assign srf_busy = busy_q;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_row;
      local_addr_data_lines.row_phase & ~local_addr_data_lines.oe_n;
   endsequence
   sequence s_col;
      local_addr_data_lines.col_phase & ~local_addr_data_lines.oe_n;
   endsequence

   property p_cycle_steps;
      take |=> s_row ##1 s_col ##1 local_addr_data_lines.oe_n ##1 local_addr_data_lines.oe_n;
   endproperty
   a_cycle_steps: assert property (p_cycle_steps)
      else $error("refresh cycle phases out of order");

   property p_row_addr;
      take |=> local_addr_data_lines.data[11:0] == $past(cnt_out[13:2]);
   endproperty
   a_row_addr: assert property (p_row_addr)
      else $error("row address does not match counter");

   property p_row_status;
      s_row |-> local_addr_data_lines.data[15:12] == 4'h8;
   endproperty
   a_row_status: assert property (p_row_status)
      else $error("row status lines wrong");

   property p_col_status;
      s_col |-> local_addr_data_lines.data[15:14] == 2'h0 &&
                local_addr_data_lines.data[13:11] == tap_q[13:11] &&
                local_addr_data_lines.data[5:0] == tap_q[5:0];
   endproperty
   a_col_status: assert property (p_col_status)
      else $error("column pan or status lines wrong");

   property p_col_or;
      s_col |-> local_addr_data_lines.data[10:6] == ($past(cnt_out[4:0]) | tap_q[10:6]);
   endproperty
   a_col_or: assert property (p_col_or)
      else $error("column overlap bits not ored");

   property p_step;
      (st_q == ST_UPDATE) & ~reload |=>
         adr_q[15:2] == $past(adr_q[15:2]) - {6'h00, $past(pitch)};
   endproperty
   a_step: assert property (p_step)
      else $error("counter not stepped by pitch");

   property p_reload;
      reload & (progressive | ~vid.even_field) |=>
         adr_q[15:2] == $past(strt_q[15:2]);
   endproperty
   a_reload: assert property (p_reload)
      else $error("frame start not reloaded");

   property p_no_vblank_req;
      vid.hblank_start & vid.vblank & ~vid.first_line_next & ~pend_q
         |=> ~pend_q;
   endproperty
   a_no_vblank_req: assert property (p_no_vblank_req)
      else $error("refresh requested inside vertical blanking");

   property p_pend_kept;
      pend_q & hold_req |=> pend_q;
   endproperty
   a_pend_kept: assert property (p_pend_kept)
      else $error("pending refresh lost under hold");

   property p_req_served;
      req_ev & ~hold_req & (st_q == ST_IDLE) & ~pend_q
         |=> ##[0:4] take;
   endproperty
   a_req_served: assert property (p_req_served)
      else $error("refresh request not served");

   property p_req_set;
      req_ev |=> pend_q;
   endproperty
   a_req_set: assert property (p_req_set)
      else $error("blanking start did not raise a request");

   property p_reload_half;
      reload & ~progressive & vid.even_field |=>
         adr_q[15:2] == $past(strt_q[15:2]) - {7'h00, $past(pitch[7:1])};
   endproperty
   a_reload_half: assert property (p_reload_half)
      else $error("even field start not offset by half a pitch");

   property p_row_invert;
      take & ~origin |=> local_addr_data_lines.data[11:0] == ~$past(adr_q[15:4]);
   endproperty
   a_row_invert: assert property (p_row_invert)
      else $error("row address not inverted for origin zero");

   property p_row_plain;
      take & origin |=> local_addr_data_lines.data[11:0] == $past(adr_q[15:4]);
   endproperty
   a_row_plain: assert property (p_row_plain)
      else $error("row address altered for origin one");

   property p_col_invert;
      take & ~origin |=> ##1
         local_addr_data_lines.data[10:6] == (~$past(adr_q[6:2]) | tap_q[10:6]);
   endproperty
   a_col_invert: assert property (p_col_invert)
      else $error("column overlap bits not inverted for origin zero");

   property p_adr_low;
      adr_q[1:0] == 2'b00;
   endproperty
   a_adr_low: assert property (p_adr_low)
      else $error("counter low bits not zero");

   property p_no_retake;
      take |=> ~take ##1 ~take ##1 ~take;
   endproperty
   a_no_retake: assert property (p_no_retake)
      else $error("new refresh taken before counter update");

   property p_served_now;
      pend_q & ~hold_req & (st_q == ST_IDLE) |=> s_row;
   endproperty
   a_served_now: assert property (p_served_now)
      else $error("pending refresh delayed without hold");

   property p_phase_excl;
      local_addr_data_lines.oe_n != (local_addr_data_lines.row_phase | local_addr_data_lines.col_phase) &&
         !(local_addr_data_lines.row_phase && local_addr_data_lines.col_phase);
   endproperty
   a_phase_excl: assert property (p_phase_excl)
      else $error("local line phases inconsistent");

   property p_vblank_first;
      vid.hblank_start & vid.vblank & vid.first_line_next |=> pend_q;
   endproperty
   a_vblank_first: assert property (p_vblank_first)
      else $error("no refresh before first active line");

   property p_field;
      reload |=> field_q == $past(vid.even_field);
   endproperty
   a_field: assert property (p_field)
      else $error("field not captured at frame reload");
endmodule : srf_addr_gen
`default_nettype wire

/* testbench/vram_model.sv */
// partner model: video ram side latching refresh transfer addresses
`timescale 1ns/1ps
`default_nettype none
module vram_model (
   // clock
   input wire logic pclk,
   // local lines from the refresh generator
   input wire srf_addr_pkg::lad_drive_t local_addr_data_lines,
   // captured transfer
   output logic xfer,
   output logic [15:0] row_w,
   output logic [15:0] col_w
);
   import srf_addr_pkg::*;
   always_ff @(posedge pclk) begin
      xfer <= 1'b0;
      if (!local_addr_data_lines.oe_n && local_addr_data_lines.row_phase) begin
         row_w <= local_addr_data_lines.data;
      end
      if (!local_addr_data_lines.oe_n && local_addr_data_lines.col_phase) begin
         col_w <= local_addr_data_lines.data;
         xfer <= 1'b1;
      end
   end
endmodule : vram_model
`default_nettype wire

/* testbench/vram_screen_refresh_addressing_test.sv */
// self-checking bench for the screen-refresh address generator
`timescale 1ns/1ps
`default_nettype none
module vram_screen_refresh_addressing_test;
   import srf_addr_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, hold_req = 1'b0, srf_busy;
   vid_timing_t vid = '0;
   lad_drive_t local_addr_data_lines;
   logic xfer;
   logic [15:0] row_w, col_w, strt, tap;
   logic [31:0] q[$];
   logic [31:0] rd, exp_w;
   logic err, origin;
   logic [13:0] cnt, co;
   logic [7:0] pitch;
   int miscompares = 0, samples_checked = 0, cyc = 0;

   always #25 pclk = ~pclk;

   srf_addr_gen DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .vid(vid),
      .hold_req(hold_req), .local_addr_data_lines(local_addr_data_lines), .srf_busy(srf_busy));
   vram_model vram (.pclk(pclk), .local_addr_data_lines(local_addr_data_lines), .xfer(xfer), .row_w(row_w),
      .col_w(col_w));

   ////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %0t reg %h exp %h", $time, got, exp);
      end
   endtask : cmp_reg

   task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %0t lad %h exp %h", $time, got, exp);
      end
   endtask : cmp_word

   // held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so a following setup never re-drives psel in this step
      @(posedge pclk);
   endtask : apb

   // vb set: the blanking line just before the first active line
   task automatic refresh(input logic hold, input logic vb);
      co = origin ? cnt : ~cnt;
      q.push_back({4'h8, co[13:2], 2'b00, tap[13:11], co[4:0] | tap[10:6],
         tap[5:0]});
      vid <= '{1'b1, vb, 1'b0, vb, 1'b1};
      hold_req <= hold;
      @(posedge pclk);
      vid.hblank_start <= 1'b0;
      if (hold) begin
         repeat (5) @(posedge pclk);
         cmp_reg({31'h0, srf_busy}, 32'h0);
         hold_req <= 1'b0;
      end
      repeat (8) @(posedge pclk);
      cnt = cnt - {6'h0, pitch};
   endtask : refresh

   always @(posedge pclk) begin
      if (xfer === 1'b1) begin
         exp_w = q.pop_front();
         cmp_word(row_w, exp_w[31:16]);
         cmp_word(col_w, exp_w[15:0]);
      end
   end

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         close_out();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(65745));
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 2; i++) begin
         origin = i[0];
         pitch = 8'h01 << ($urandom % 8);
         strt = 16'($urandom);
         tap = 16'($urandom) & 16'h3FFF;
         apb(1'b1, OFF_CTL, {16'h0, origin, 4'h0, origin, pitch, 2'b00});
         apb(1'b1, OFF_STRT, {16'h0, strt});
         apb(1'b1, OFF_TAP, {16'h0, tap});
         apb(1'b0, OFF_STRT, 32'h0);
         cmp_reg(rd, {16'h0, strt[15:2], 2'b00});
         // reload during vertical blanking, even field
         vid <= '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
         @(posedge pclk);
         vid <= '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
         repeat (6) @(posedge pclk);
         cmp_reg({31'h0, srf_busy}, 32'h0);
         cnt = strt[15:2] - (origin ? 14'h0 : {7'h0, pitch[7:1]});
         apb(1'b0, OFF_ADR, 32'h0);
         cmp_reg(rd, {16'h0, cnt, 2'b00});
         refresh(1'b0, 1'b1);
         refresh(1'b0, 1'b0);
         refresh(1'b1, 1'b0);
         apb(1'b0, OFF_ADR, 32'h0);
         cmp_reg(rd, {16'h0, cnt, 2'b00});
      end
      apb(1'b0, 8'h20, 32'h0);
      cmp_reg({31'h0, err}, 32'h1);
      cmp_reg(rd, 32'h0);
      repeat (4) @(posedge pclk);
      cmp_reg(q.size(), 32'h0);
      close_out();
   end
endmodule : vram_screen_refresh_addressing_test
`default_nettype wire
